// ===== spp_cfg.svh
// holds constants of the shared pin parallel port
// assumes inclusion by bare name from the design files
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH
// ==========================================
// port geometry and reset values
`define SPP_WIDTH        16
`define SPP_DIR_RESET    16'hffff
`define SPP_LATCH_RESET  16'h0000
`define SPP_IMPL_MASK    16'hffff
// input-only pin positions
`define SPP_IN_ONLY_A    13
`define SPP_IN_ONLY_B    14
`endif

// ===== spp_pkg.sv
// holds the types of the shared pin parallel port
// assumes spp_cfg.svh is on the include path
`include "spp_cfg.svh"
package spp_pkg;
    typedef logic [`SPP_WIDTH-1:0] spp_word_type;
    // register selected by a cpu access
    typedef enum logic [1:0] {
        SPP_SEL_DIR   = 2'b00,
        SPP_SEL_LATCH = 2'b01,
        SPP_SEL_PINS  = 2'b10,
        SPP_SEL_NONE  = 2'b11
    } spp_sel_type;
endpackage : spp_pkg

// ===== spp_sync.sv
// holds a two-flop synchroniser for a bus of pin levels
// assumes the pins are asynchronous to sys_clk
`timescale 1ns/1ns
module spp_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : spp_sync

// ===== spp_port.sv
// holds the shared pin parallel port: direction, latch, pin read, ownership mux
// assumes a same-clock cpu access port and peripheral signals on sys_clk
// Operation
// R01: a peripheral sharing a pin takes priority over the port for it.
// R02: per pin, two muxes pick peripheral or port for output data and driver control.
// R03: the port's output value never reaches the input of a sharing peripheral.
// R04: an enabled, driving peripheral disables the port output driver for that bit.
// R05: a peripheral-owned pin still reads back through the pin-level path.
// R06: an enabled peripheral that is not driving lets the port drive the pin.
// R07: a direction bit of one makes the pin an input, zero an output.
// R08: on reset every direction bit is set so all pins are inputs.
// R09: reading the latch returns latch contents; writing it updates the latch.
// R10: reading pin level returns pin levels; writing it updates the latch.
// R11: unimplemented bits read zero in direction, latch and pin level.
// R12: a pin shared only with an input function is a dedicated port pin.
// R13: the two input-only pins never enable an output driver.
// R14: pin levels are synchronised before pin-level reads.
// R15: latch and direction stay writable and kept while a peripheral owns the pin.
`timescale 1ns/1ns
`include "spp_cfg.svh"
module spp_port #(
    parameter int                     WIDTH     = `SPP_WIDTH,
    parameter logic [WIDTH-1:0]       IMPL_MASK = WIDTH'(`SPP_IMPL_MASK)
) (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    input  wire spp_pkg::spp_sel_type  cpu_sel,
    input  wire logic                  cpu_wr,
    input  wire logic [WIDTH-1:0]      cpu_wdata,
    output logic      [WIDTH-1:0]      cpu_rdata,
    input  wire logic [WIDTH-1:0]      periph_en,
    input  wire logic [WIDTH-1:0]      periph_drive,
    input  wire logic [WIDTH-1:0]      periph_out,
    output logic      [WIDTH-1:0]      periph_in,
    input  wire logic [WIDTH-1:0]      pin_in,
    output logic      [WIDTH-1:0]      pin_out,
    output logic      [WIDTH-1:0]      pin_oe_n
);
    // ==========================================
    // masks
    localparam logic [WIDTH-1:0] IN_ONLY =
        WIDTH'((1 << `SPP_IN_ONLY_A) | (1 << `SPP_IN_ONLY_B));
    // input-only pins treated as unimplemented for output purposes
    localparam logic [WIDTH-1:0] OUT_OK = IMPL_MASK & ~IN_ONLY; // see R13
    localparam logic [WIDTH-1:0] DIR_RST = WIDTH'(`SPP_DIR_RESET);

    logic [WIDTH-1:0] pin_direction_reg;
    logic [WIDTH-1:0] output_latch_reg;
    logic [WIDTH-1:0] pin_level_reg;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] owned;
    logic [WIDTH-1:0] data_next;
    logic [WIDTH-1:0] oe_n_next;
    logic [WIDTH-1:0] port_drv_next;
    logic [WIDTH-1:0] port_drv_reg;
    logic [WIDTH-1:0] port_drv_dly1_reg;
    logic [WIDTH-1:0] port_drv_dly2_reg;

    // ==========================================
    // decode helpers
    // bits the port drives: output direction and no peripheral owner
    function automatic logic [WIDTH-1:0] port_drive_mask(
        input logic [WIDTH-1:0] own_bits,
        input logic [WIDTH-1:0] dir_bits
    );
        return ~own_bits & ~dir_bits & OUT_OK;
    endfunction : port_drive_mask

    // a cpu write aimed at the given register
    function automatic logic write_hits(
        input logic                 wr,
        input spp_pkg::spp_sel_type sel,
        input spp_pkg::spp_sel_type target
    );
        return wr && sel == target;
    endfunction : write_hits

    // ==========================================
    // pin synchroniser
    spp_sync #(.WIDTH(WIDTH)) u_sync (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in (pin_in),
        .sync_out (pin_sync)
    ); // see R14

    // ==========================================
    // direction bits
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_direction_reg <= DIR_RST & IMPL_MASK; // see R08 R11
        end else if (clk_en && write_hits(cpu_wr, cpu_sel, spp_pkg::SPP_SEL_DIR)) begin
            // kept whatever the pin owner, so the port resumes cleanly
            pin_direction_reg <= (cpu_wdata | IN_ONLY) & IMPL_MASK; // see R15 R13
        end
    end

    // ==========================================
    // output latch, written through latch and pin-level selects
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            output_latch_reg <= WIDTH'(`SPP_LATCH_RESET);
        end else if (clk_en && (write_hits(cpu_wr, cpu_sel, spp_pkg::SPP_SEL_LATCH) ||
                                write_hits(cpu_wr, cpu_sel, spp_pkg::SPP_SEL_PINS))) begin
            output_latch_reg <= cpu_wdata & IMPL_MASK; // see R09 R10 R15
        end
    end

    // ==========================================
    // pin level register, always sampling even when a peripheral owns the pin
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_level_reg <= '0;
        end else if (clk_en) begin
            pin_level_reg <= pin_sync & IMPL_MASK; // see R05 R11 R14
        end
    end

    // ==========================================
    // read mux
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_rdata <= '0;
        end else if (clk_en) begin
            unique case (cpu_sel)
                spp_pkg::SPP_SEL_DIR:   cpu_rdata <= pin_direction_reg;
                spp_pkg::SPP_SEL_LATCH: cpu_rdata <= output_latch_reg; // see R09
                spp_pkg::SPP_SEL_PINS:  cpu_rdata <= pin_level_reg;    // see R10
                spp_pkg::SPP_SEL_NONE:  cpu_rdata <= '0;
            endcase
        end
    end

    // ==========================================
    // ownership muxes
    always_comb begin
        // a peripheral owns only while enabled and driving
        owned     = periph_en & periph_drive & OUT_OK;                 // see R01 R04 R06 R12
        data_next = (owned & periph_out) | (~owned & output_latch_reg); // see R02
        // port drives when its direction bit is zero
        port_drv_next = port_drive_mask(owned, pin_direction_reg);         // see R07 R13
        oe_n_next = ~(owned | port_drv_next);                              // see R02
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_out  <= '0;
            pin_oe_n <= '1;
        end else if (clk_en) begin
            pin_out  <= data_next & OUT_OK;
            pin_oe_n <= oe_n_next;
        end
    end

    // ==========================================
    // port drive history, covering the synchroniser delay
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            port_drv_reg      <= '0;
            port_drv_dly1_reg <= '0;
            port_drv_dly2_reg <= '0;
        end else if (clk_en) begin
            port_drv_reg      <= port_drv_next;
            port_drv_dly1_reg <= port_drv_reg;
            port_drv_dly2_reg <= port_drv_dly1_reg;
        end
    end

    // peripherals see the pin only, never the latch; a port-driven pin is hidden
    // synchronised levels lag the driver by up to three edges, so the mask spans
    // that history; a released pin reads zero a few edges longer as a result
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            periph_in <= '0;
        end else if (clk_en) begin
            periph_in <= pin_sync & ~(port_drv_next | port_drv_reg |
                                      port_drv_dly1_reg | port_drv_dly2_reg); // see R03
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_in_only_never_out: assert property (&pin_oe_n[`SPP_IN_ONLY_B:`SPP_IN_ONLY_A]) // see R13
        else $error("input-only pin driven");
    a_periph_owns_pin: assert property (clk_en && (periph_en[0] && periph_drive[0]) // see R01
        |=> !pin_oe_n[0] && pin_out[0] == $past(periph_out[0]))
        else $error("peripheral lost pin 0");
    a_port_drives_pin: assert property (clk_en && !(periph_en[0] && periph_drive[0]) // see R06
        && !pin_direction_reg[0] |=> !pin_oe_n[0] && pin_out[0] == $past(output_latch_reg[0]))
        else $error("port output wrong on pin 0");
    a_dir_input_off: assert property (clk_en && !(periph_en[1] && periph_drive[1]) // see R07
        && pin_direction_reg[1] |=> pin_oe_n[1])
        else $error("input pin driven");
    a_latch_write_read: assert property (clk_en && cpu_wr // see R10
        && cpu_sel == spp_pkg::SPP_SEL_PINS
        |=> output_latch_reg == ($past(cpu_wdata) & IMPL_MASK))
        else $error("pin write missed latch");
    a_pin_read_path: assert property (clk_en && cpu_sel == spp_pkg::SPP_SEL_PINS // see R05
        |=> cpu_rdata == $past(pin_level_reg))
        else $error("pin read wrong");
    a_latch_read_path: assert property (clk_en && cpu_sel == spp_pkg::SPP_SEL_LATCH // see R09
        |=> cpu_rdata == $past(output_latch_reg))
        else $error("latch read wrong");
    a_no_loop_through: assert property (clk_en && !pin_direction_reg[0] && !owned[0] // see R03
        |=> !periph_in[0])
        else $error("port output looped to peripheral");
    a_unimpl_zero: assert property ((pin_direction_reg & ~IMPL_MASK) == '0 // see R11
        && (output_latch_reg & ~IMPL_MASK) == '0)
        else $error("unimplemented bit set");
    a_dir_kept_owned: assert property (clk_en && owned[0] && !cpu_wr // see R15
        |=> $stable(pin_direction_reg[0]) && $stable(output_latch_reg[0]))
        else $error("control lost under peripheral");
    a_latch_wr_owned: assert property (clk_en && owned[0] && cpu_wr // see R15
        && cpu_sel == spp_pkg::SPP_SEL_LATCH |=> output_latch_reg[0] == $past(cpu_wdata[0]))
        else $error("latch write lost under peripheral");
    a_unimpl_read_zero: assert property ((pin_level_reg & ~IMPL_MASK) == '0 // see R11
        && (cpu_rdata & ~IMPL_MASK) == '0)
        else $error("unimplemented bit read nonzero");

    c_periph_drive: cover property (owned[0] ##1 !owned[0]);
    c_port_out:     cover property (!pin_oe_n[0] && !owned[0]);
    c_pin_write:    cover property (cpu_wr && cpu_sel == spp_pkg::SPP_SEL_PINS);
    c_idle_periph:  cover property (periph_en[4] && !periph_drive[4] && !pin_oe_n[4]);
    c_freeze:       cover property (!clk_en ##1 clk_en);
endmodule : spp_port

// ===== spp_pins.sv
// holds a model of the board pins seen by the shared pin port
// assumes the bench supplies the level of every pin nobody drives
`timescale 1ns/1ns
module spp_pins (
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe_n,
    input  wire logic [15:0] ext_level,
    output logic      [15:0] pin_in
);
    // ==========================================
    // pin resolution
    // no pull on the board, so a released pin shows only the outside level
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : spp_pins

// ===== testbench.sv
// holds the self-checking bench of the shared pin parallel port
// assumes spp_pkg, spp_port and spp_pins compiled before it
`timescale 1ns/1ns
module testbench;
    logic                 sys_clk = 1'b0;
    logic                 resetn, clk_en, cpu_wr;
    spp_pkg::spp_sel_type cpu_sel;
    logic [15:0]          cpu_wdata, cpu_rdata, periph_en, periph_drive, periph_out;
    logic [15:0]          periph_in, pin_in, pin_out, pin_oe_n, ext_level;
    int                   failures = 0;
    int                   total_checks = 0;
    always #5 sys_clk = ~sys_clk;
    // ==========================================
    // design and pins; bit 15 left unimplemented
    spp_port #(.WIDTH(16), .IMPL_MASK(16'h7fff)) uut (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(clk_en), .cpu_sel(cpu_sel), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .periph_en(periph_en), .periph_drive(periph_drive),
        .periph_out(periph_out), .periph_in(periph_in), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    spp_pins pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
        .pin_in(pin_in));
    // ==========================================
    // shared tasks
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task wr(input spp_pkg::spp_sel_type s, input logic [15:0] d);
        @(posedge sys_clk);
        cpu_sel <= s;
        cpu_wr <= 1'b1;
        cpu_wdata <= d;
        @(posedge sys_clk);
        cpu_wr <= 1'b0;
        cpu_sel <= spp_pkg::SPP_SEL_NONE;
    endtask : wr
    task rd(input spp_pkg::spp_sel_type s, input string name, input logic [15:0] exp);
        @(posedge sys_clk);
        cpu_sel <= s;
        tick(2);
        chk(name, exp, cpu_rdata);
    endtask : rd
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    // ==========================================
    // scenarios
    task t_reset;
        chk("pin_oe_n", 16'hffff, pin_oe_n);
        rd(spp_pkg::SPP_SEL_DIR, "direction", 16'h7fff);
        rd(spp_pkg::SPP_SEL_LATCH, "latch", 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task t_regs;
        wr(spp_pkg::SPP_SEL_LATCH, 16'ha5a5);
        rd(spp_pkg::SPP_SEL_LATCH, "latch", 16'h25a5);
        wr(spp_pkg::SPP_SEL_PINS, 16'h1234);
        rd(spp_pkg::SPP_SEL_LATCH, "latch", 16'h1234);
        rd(spp_pkg::SPP_SEL_PINS, "pins", 16'h7fff);
        $display("test registers done");
    endtask : t_regs
    task t_dir;
        wr(spp_pkg::SPP_SEL_DIR, 16'h0000);
        rd(spp_pkg::SPP_SEL_DIR, "direction", 16'h6000);
        tick(6);
        chk("pin_oe_n", 16'he000, pin_oe_n);
        chk("pin_out", 16'h1234, pin_out & 16'h1fff);
        chk("periph_in", 16'h0000, periph_in & 16'h1fff);
        rd(spp_pkg::SPP_SEL_PINS, "pins", 16'h7234);
        $display("test direction done");
    endtask : t_dir
    task t_periph;
        @(posedge sys_clk);
        periph_en <= 16'h00ff;
        periph_drive <= 16'h000f;
        periph_out <= 16'h000a;
        tick(6);
        chk("pin_out", 16'h003a, pin_out & 16'h00ff);
        chk("pin_oe_n", 16'he000, pin_oe_n);
        chk("periph_in", 16'h000a, periph_in & 16'h00ff);
        rd(spp_pkg::SPP_SEL_PINS, "pins", 16'h723a);
        wr(spp_pkg::SPP_SEL_LATCH, 16'h0005);
        rd(spp_pkg::SPP_SEL_LATCH, "latch", 16'h0005);
        @(posedge sys_clk);
        periph_en <= 16'h0000;
        tick(6);
        chk("pin_out", 16'h0005, pin_out & 16'h00ff);
        $display("test peripheral done");
    endtask : t_periph
    task t_freeze;
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(spp_pkg::SPP_SEL_LATCH, 16'h00f0);
        tick(3);
        chk("pin_out", 16'h0005, pin_out);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(spp_pkg::SPP_SEL_LATCH, "latch", 16'h0005);
        @(posedge sys_clk);
        resetn <= 1'b0;
        tick(2);
        chk("pin_oe_n", 16'hffff, pin_oe_n);
        @(posedge sys_clk);
        resetn <= 1'b1;
        tick(1);
        rd(spp_pkg::SPP_SEL_DIR, "direction", 16'h7fff);
        $display("test freeze and reset done");
    endtask : t_freeze
    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        cpu_wr = 1'b0;
        cpu_sel = spp_pkg::SPP_SEL_NONE;
        cpu_wdata = 16'h0000;
        periph_en = 16'h0000;
        periph_drive = 16'h0000;
        periph_out = 16'h0000;
        ext_level = 16'hffff;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        tick(1);
        t_reset();
        t_regs();
        t_dir();
        t_periph();
        t_freeze();
        close_out();
    end
endmodule : testbench
